/* common/issue_timing_pkg.sv */
// shared types and constants for the in-order memory/fp issue timing block
// assumes one core clock; all timing figures below are in core clock cycles
package issue_timing_pkg;

   localparam int NTHR = 2;
   localparam int ADDR_W = 12;
   localparam int TMR_W = 7;
   localparam int EVT_W = 32;

   // store forwarding
   localparam logic [2:0] FWD_MAX_LOG2 = 3'h3;
   localparam logic [TMR_W-1:0] FWD_DELAY = 7'h06;

   // data cache geometry: 64-byte line of sixteen 4-byte chunks
   localparam int LINE_OFS_W = 6;
   localparam int CHUNK_OFS_W = 2;
   localparam logic [6:0] LINE_BYTES = 7'h40;
   localparam logic [6:0] SPLIT_BYTES = 7'h10;
   localparam logic [2:0] SPLIT_LOAD_LOG2 = 3'h4;
   localparam logic [2:0] CHUNK_LOG2 = 3'h2;
   localparam logic [TMR_W-1:0] SPLIT_PENALTY = 7'h0E;
   localparam logic [TMR_W-1:0] SUBCHUNK_DELAY = 7'h01;

   // segment-dependent spacing between memory operations
   localparam logic [TMR_W-1:0] GAP_NONE = 7'h01;
   localparam logic [TMR_W-1:0] GAP_TWO = 7'h02;
   localparam logic [TMR_W-1:0] GAP_NINE = 7'h09;

   // fp and divider timing
   localparam logic [TMR_W-1:0] FP_DEP_DELAY = 7'h02;
   localparam logic [TMR_W-1:0] PD_MUL_LAT = 7'h09;
   localparam logic [TMR_W-1:0] DIV_SETUP = 7'h02;

   typedef enum logic [2:0] {
      DATA_SEGMENT_REG = 3'h0,
      EXTRA_SEGMENT_REG = 3'h1,
      AUX_SEGMENT_REG_A = 3'h2,
      AUX_SEGMENT_REG_B = 3'h3,
      CODE_SEGMENT_REG = 3'h4,
      STACK_SEGMENT_REG = 3'h5
   } seg_sel_t;

   typedef enum logic [1:0] {
      SLOT_EMPTY = 2'h0,
      SLOT_HELD = 2'h1,
      SLOT_PENALTY = 2'h3
   } slot_state_t;

   typedef struct packed {
      logic is_mem;
      logic is_load;
      logic is_int;
      logic is_fp;
      logic dep_fp;
      logic is_pd;
      logic is_div;
      logic string_dst;
      seg_sel_t seg;
      logic base_nonzero;
      logic base_line_aligned;
      logic [2:0] size_log2;
      logic [ADDR_W-1:0] addr;
      logic [6:0] div_bits;
      logic [6:0] div_lz;
   } issue_req_t;

   typedef struct packed {
      logic valid;
      logic is_int;
      logic [2:0] size_log2;
      logic [ADDR_W-1:0] addr;
   } store_ent_t;

endpackage

/* design/gap_timer.sv */
// down-counting spacing timer: busy while a loaded gap is still running
// assumes load and load_val come from logic on the same clock
`timescale 1ns/1ps
module gap_timer #(
   parameter int W = 7
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic busy
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (load)
      begin
         nxt_cnt = load_val;
      end
      else if (cnt_ff != '0)
      begin
         nxt_cnt = cnt_ff - W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_ff <= '0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign busy = (cnt_ff != '0);

endmodule // gap_timer

/* design/inorder_mem_issue_timing.sv */
// issue timing and hazard control for a two-thread in-order back end
// assumes each thread holds its oldest instruction on req until taken,
// and that the store buffer presents its youngest pending store per thread
//
// How it works
// - forward only integer loads, never fp or simd
// - forward needs equal size and equal address
// - no forwarding above 8 bytes
// - forward match uses low 12 address bits
// - overlapping unforwardable load is delayed and reissued
// - line is sixteen 4-byte chunks
// - narrow same-chunk different-byte access adds delay
// - 16-byte line-crossing load costs 14 cycles
// - non-zero segment base delays memory operations
// - unaligned base: one memory op per 9
// - data segment, aligned base: one per 2
// - aux segments one per 2 unless the base is non-zero and unaligned
// - extra segment string destination: one per 2
// - other extra segment use: one per 9
// - code and stack segments: one per 9
// - expensive access blocks all younger instructions of its own thread; the other thread keeps issuing
// - count reissued memory instructions
// - fp result consumers wait two extra cycles
// - packed double multiply occupies unit 9 cycles
// - radix-2 divider, one quotient bit per cycle
// - divider time follows operand size and value
// - one divider shared by both threads
// - count divides and divider busy cycles
`timescale 1ns/1ps
module inorder_mem_issue_timing (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] req_valid,
   input wire issue_timing_pkg::issue_req_t [1:0] req,
   input wire issue_timing_pkg::store_ent_t [1:0] pend_store,
   output wire logic [1:0] in_ready_ff,
   output wire logic [1:0] issue_ff,
   output wire logic [1:0] fwd_hit_ff,
   output wire logic [1:0] mem_event_a_ff,
   output logic [issue_timing_pkg::EVT_W-1:0] mem_event_a_cnt_ff,
   output logic [issue_timing_pkg::EVT_W-1:0] div_op_cnt_ff,
   output logic [issue_timing_pkg::EVT_W-1:0] div_busy_cnt_ff
);

   localparam int TW = issue_timing_pkg::TMR_W;
   localparam int EVT_W = issue_timing_pkg::EVT_W;

   logic [1:0] want_pd;
   logic [1:0] want_div;
   logic [1:0] pd_gnt;
   logic [1:0] div_gnt;
   logic [1:0] issue_now;
   logic [1:0] mem_event_a_now;
   logic [TW-1:0] div_len [2];
   logic pd_busy;
   logic div_busy;
   logic rr_ff;
   logic nxt_rr;
   logic pd_load;
   logic div_load;
   logic [TW-1:0] div_val;
   logic [issue_timing_pkg::EVT_W-1:0] nxt_mem_event_a_cnt;
   logic [issue_timing_pkg::EVT_W-1:0] nxt_div_op_cnt;
   logic [issue_timing_pkg::EVT_W-1:0] nxt_div_busy_cnt;

   for (genvar t = 0; t < issue_timing_pkg::NTHR; t++)
   begin : g_thr
      issue_timing_pkg::slot_state_t st_ff;
      issue_timing_pkg::slot_state_t nxt_st;
      issue_timing_pkg::issue_req_t cur_ff;
      issue_timing_pkg::issue_req_t nxt_cur;
      issue_timing_pkg::store_ent_t se;
      logic [issue_timing_pkg::ADDR_W-1:0] last_addr_ff;
      logic [issue_timing_pkg::ADDR_W-1:0] nxt_last_addr;
      logic last_valid_ff;
      logic nxt_last_valid;
      logic ready_ff;
      logic nxt_ready;
      logic iss_ff;
      logic fwd_ff;
      logic ev_ff;
      logic nxt_ev;
      logic mem_busy;
      logic fp_busy;
      logic blk_busy;
      logic blk_load;
      logic [TW-1:0] blk_val;
      logic [TW-1:0] pen;
      logic [TW-1:0] gap;
      logic [12:0] ld_end;
      logic [12:0] st_end;
      logic ovl;
      logic fwd_ok;
      logic split;
      logic narrow;
      logic ok_c;

      assign se = pend_store[t];

      // hazard evaluation for the held instruction
      always_comb
      begin
         ld_end = {1'b0, cur_ff.addr} + (13'h1 << cur_ff.size_log2);
         st_end = {1'b0, se.addr} + (13'h1 << se.size_log2);
         // only the low address bits take part, so aliases match
         ovl = se.valid && cur_ff.is_mem && cur_ff.is_load
            && ({1'b0, cur_ff.addr} < st_end)
            && ({1'b0, se.addr} < ld_end);
         fwd_ok = ovl && cur_ff.is_int && se.is_int
            && (cur_ff.size_log2 == se.size_log2)
            && (cur_ff.addr == se.addr)
            && (cur_ff.size_log2 <= issue_timing_pkg::FWD_MAX_LOG2);
         split = cur_ff.is_mem && cur_ff.is_load
            && (cur_ff.size_log2 == issue_timing_pkg::SPLIT_LOAD_LOG2)
            && (({1'b0, cur_ff.addr[issue_timing_pkg::LINE_OFS_W-1:0]}
               + issue_timing_pkg::SPLIT_BYTES)
               > issue_timing_pkg::LINE_BYTES);
         narrow = cur_ff.is_mem && last_valid_ff
            && (cur_ff.size_log2 < issue_timing_pkg::CHUNK_LOG2)
            && (cur_ff.addr[issue_timing_pkg::ADDR_W-1:
               issue_timing_pkg::CHUNK_OFS_W]
               == last_addr_ff[issue_timing_pkg::ADDR_W-1:
               issue_timing_pkg::CHUNK_OFS_W])
            && (cur_ff.addr[issue_timing_pkg::CHUNK_OFS_W-1:0]
               != last_addr_ff[issue_timing_pkg::CHUNK_OFS_W-1:0]);
         pen = '0;
         if (split)
         begin
            pen = issue_timing_pkg::SPLIT_PENALTY;
         end
         else if (ovl && !fwd_ok)
         begin
            pen = issue_timing_pkg::FWD_DELAY;
         end
         else if (narrow)
         begin
            pen = issue_timing_pkg::SUBCHUNK_DELAY;
         end
         gap = issue_timing_pkg::GAP_NONE;
         if (cur_ff.seg == issue_timing_pkg::AUX_SEGMENT_REG_A
            || cur_ff.seg == issue_timing_pkg::AUX_SEGMENT_REG_B)
         begin
            gap = issue_timing_pkg::GAP_TWO;
         end
         if (cur_ff.base_nonzero && !cur_ff.base_line_aligned)
         begin
            gap = issue_timing_pkg::GAP_NINE;
         end
         else if (cur_ff.base_nonzero)
         begin
            unique case (cur_ff.seg)
               issue_timing_pkg::DATA_SEGMENT_REG:
                  gap = issue_timing_pkg::GAP_TWO;
               issue_timing_pkg::AUX_SEGMENT_REG_A,
               issue_timing_pkg::AUX_SEGMENT_REG_B:
                  gap = issue_timing_pkg::GAP_TWO;
               issue_timing_pkg::EXTRA_SEGMENT_REG:
                  gap = cur_ff.string_dst ? issue_timing_pkg::GAP_TWO
                     : issue_timing_pkg::GAP_NINE;
               default:
                  gap = issue_timing_pkg::GAP_NINE;
            endcase
         end
         ok_c = ((st_ff == issue_timing_pkg::SLOT_HELD && pen == '0)
            || st_ff == issue_timing_pkg::SLOT_PENALTY)
            && !blk_busy
            && !(cur_ff.is_mem && mem_busy)
            && !(cur_ff.dep_fp && fp_busy);
      end

      assign want_pd[t] = ok_c && cur_ff.is_pd;
      assign want_div[t] = ok_c && cur_ff.is_div;
      assign issue_now[t] = ok_c && (!cur_ff.is_pd || pd_gnt[t])
         && (!cur_ff.is_div || div_gnt[t]);
      assign mem_event_a_now[t] = nxt_ev;
      // radix-2: one quotient bit per cycle over the significant bits
      assign div_len[t] = ((cur_ff.div_bits > cur_ff.div_lz)
         ? (cur_ff.div_bits - cur_ff.div_lz) : 7'h01)
         + issue_timing_pkg::DIV_SETUP;

      // slot holds the oldest instruction until every stall clears
      always_comb
      begin
         nxt_st = st_ff;
         nxt_cur = cur_ff;
         nxt_ev = 1'b0;
         blk_load = 1'b0;
         blk_val = '0;
         nxt_last_addr = last_addr_ff;
         nxt_last_valid = last_valid_ff;
         unique case (st_ff)
            issue_timing_pkg::SLOT_EMPTY:
            begin
               if (req_valid[t] && ready_ff)
               begin
                  nxt_cur = req[t];
                  nxt_st = issue_timing_pkg::SLOT_HELD;
               end
            end
            issue_timing_pkg::SLOT_HELD:
            begin
               if (pen != '0)
               begin
                  nxt_st = issue_timing_pkg::SLOT_PENALTY;
                  blk_load = 1'b1;
                  blk_val = pen - 7'h01;
                  nxt_ev = ovl && !fwd_ok;
               end
               else if (issue_now[t])
               begin
                  nxt_st = issue_timing_pkg::SLOT_EMPTY;
               end
            end
            issue_timing_pkg::SLOT_PENALTY:
            begin
               if (issue_now[t])
               begin
                  nxt_st = issue_timing_pkg::SLOT_EMPTY;
               end
            end
            default:
               nxt_st = issue_timing_pkg::SLOT_EMPTY;
         endcase
         if (issue_now[t] && cur_ff.is_mem)
         begin
            nxt_last_addr = cur_ff.addr;
            nxt_last_valid = 1'b1;
         end
         nxt_ready = (nxt_st == issue_timing_pkg::SLOT_EMPTY);
      end

      always_ff @(posedge clk)
      begin
         if (!rst_n)
         begin
            st_ff <= issue_timing_pkg::SLOT_EMPTY;
            cur_ff <= '0;
            last_addr_ff <= '0;
            last_valid_ff <= 1'b0;
            ready_ff <= 1'b0;
            iss_ff <= 1'b0;
            fwd_ff <= 1'b0;
            ev_ff <= 1'b0;
         end
         else
         begin
            st_ff <= nxt_st;
            cur_ff <= nxt_cur;
            last_addr_ff <= nxt_last_addr;
            last_valid_ff <= nxt_last_valid;
            ready_ff <= nxt_ready;
            iss_ff <= issue_now[t];
            fwd_ff <= issue_now[t] && fwd_ok;
            ev_ff <= nxt_ev;
         end
      end

      gap_timer #(.W(TW)) u_mem_gap (
         .clk(clk),
         .rst_n(rst_n),
         .load(issue_now[t] && cur_ff.is_mem),
         .load_val(gap - 7'h01),
         .busy(mem_busy)
      );

      gap_timer #(.W(TW)) u_fp_dep (
         .clk(clk),
         .rst_n(rst_n),
         .load(issue_now[t] && cur_ff.is_fp),
         .load_val(issue_timing_pkg::FP_DEP_DELAY),
         .busy(fp_busy)
      );

      gap_timer #(.W(TW)) u_block (
         .clk(clk),
         .rst_n(rst_n),
         .load(blk_load),
         .load_val(blk_val),
         .busy(blk_busy)
      );

      assign in_ready_ff[t] = ready_ff;
      assign issue_ff[t] = iss_ff;
      assign fwd_hit_ff[t] = fwd_ff;
      assign mem_event_a_ff[t] = ev_ff;
   end

   // shared packed-double unit and divider, round-robin on contention
   always_comb
   begin
      pd_gnt = 2'h0;
      div_gnt = 2'h0;
      nxt_rr = rr_ff;
      if (!pd_busy)
      begin
         if (want_pd == 2'h3)
         begin
            pd_gnt[rr_ff] = 1'b1;
            nxt_rr = !rr_ff;
         end
         else
         begin
            pd_gnt = want_pd;
         end
      end
      if (!div_busy)
      begin
         if (want_div == 2'h3)
         begin
            div_gnt[rr_ff] = 1'b1;
            nxt_rr = !rr_ff;
         end
         else
         begin
            div_gnt = want_div;
         end
      end
      pd_load = pd_gnt != 2'h0;
      div_load = div_gnt != 2'h0;
      div_val = div_gnt[1] ? div_len[1] - 7'h01 : div_len[0] - 7'h01;
      nxt_mem_event_a_cnt = mem_event_a_cnt_ff
         + EVT_W'(mem_event_a_now[0]) + EVT_W'(mem_event_a_now[1]);
      nxt_div_op_cnt = div_op_cnt_ff + EVT_W'(div_load);
      // the granting cycle counts as busy, so one divide is div_len cycles
      nxt_div_busy_cnt = div_busy_cnt_ff
         + EVT_W'(div_busy || div_load);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rr_ff <= 1'b0;
         mem_event_a_cnt_ff <= '0;
         div_op_cnt_ff <= '0;
         div_busy_cnt_ff <= '0;
      end
      else
      begin
         rr_ff <= nxt_rr;
         mem_event_a_cnt_ff <= nxt_mem_event_a_cnt;
         div_op_cnt_ff <= nxt_div_op_cnt;
         div_busy_cnt_ff <= nxt_div_busy_cnt;
      end
   end

   gap_timer #(.W(TW)) u_pd_unit (
      .clk(clk),
      .rst_n(rst_n),
      .load(pd_load),
      .load_val(issue_timing_pkg::PD_MUL_LAT - 7'h01),
      .busy(pd_busy)
   );

   gap_timer #(.W(TW)) u_divider (
      .clk(clk),
      .rst_n(rst_n),
      .load(div_load),
      .load_val(div_val),
      .busy(div_busy)
   );

endmodule // inorder_mem_issue_timing

/* testbench/issue_timing_chk_props.sv */
// assertions on the ports of the issue timing block
// assumes thread 0 carries the directed traffic
`timescale 1ns/1ps
module issue_timing_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] req_valid,
   input wire issue_timing_pkg::issue_req_t [1:0] req,
   input wire issue_timing_pkg::store_ent_t [1:0] pend_store,
   input wire logic [1:0] in_ready_ff,
   input wire logic [1:0] issue_ff,
   input wire logic [1:0] fwd_hit_ff,
   input wire logic [1:0] mem_event_a_ff,
   input wire logic [issue_timing_pkg::EVT_W-1:0] mem_event_a_cnt_ff,
   input wire logic [issue_timing_pkg::EVT_W-1:0] div_op_cnt_ff,
   input wire logic [issue_timing_pkg::EVT_W-1:0] div_busy_cnt_ff
);
   issue_timing_pkg::issue_req_t held_ff;
   issue_timing_pkg::issue_req_t nxt_held;
   logic [7:0] lat_ff;
   logic [7:0] nxt_lat;
   logic split;
   // last instruction taken on thread 0 and cycles since its take
   always_comb
   begin
      nxt_held = held_ff;
      nxt_lat = lat_ff + 8'h01;
      if (req_valid[0] && in_ready_ff[0])
      begin
         nxt_held = req[0];
         nxt_lat = 8'h01;
      end
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         held_ff <= '0;
         lat_ff <= 8'h00;
      end
      else
      begin
         held_ff <= nxt_held;
         lat_ff <= nxt_lat;
      end
   end
   assign split = held_ff.is_load && held_ff.addr[5:0] > 6'h30
      && held_ff.size_log2 == issue_timing_pkg::SPLIT_LOAD_LOG2;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_split_cost: assert property (issue_ff[0] && split |->
      lat_ff == 8'h10)
      else $error("split load issue time wrong");
   a_fwd_legal: assert property (fwd_hit_ff[0] |-> issue_ff[0]
      && held_ff.is_int && pend_store[0].is_int
      && held_ff.size_log2 <= issue_timing_pkg::FWD_MAX_LOG2)
      else $error("forward on unsupported load");
   a_fwd_match: assert property (fwd_hit_ff[0] |->
      held_ff.addr == pend_store[0].addr
      && held_ff.size_log2 == pend_store[0].size_log2)
      else $error("forward without exact match");
   a_mem_event_a_wait: assert property (mem_event_a_ff[0] |->
      lat_ff == 8'h02 ##[6:7] issue_ff[0])
      else $error("reissued load timing wrong");
   a_pd_spacing: assert property (issue_ff[0] && held_ff.is_pd |=>
      !(issue_ff[0] && held_ff.is_pd) [*8])
      else $error("packed double issued too soon");
   a_div_spacing: assert property (issue_ff[0] && held_ff.is_div |=>
      !(issue_ff[0] && held_ff.is_div) [*2])
      else $error("divide issued too soon");
   a_fp_wait: assert property (issue_ff[0] && held_ff.is_fp |=>
      !(issue_ff[0] && held_ff.dep_fp) [*2])
      else $error("fp consumer issued too soon");
   a_mem_event_a_count: assert property ($changed(mem_event_a_cnt_ff) &&
      $past(rst_n) |-> mem_event_a_ff != 2'h0 || $past(mem_event_a_ff) != 2'h0)
      else $error("mem_event_a count moved without event");
   a_busy_count: assert property ($changed(div_busy_cnt_ff) &&
      $past(rst_n) |-> div_busy_cnt_ff == $past(div_busy_cnt_ff) + 1)
      else $error("busy count step wrong");
   cover property (issue_ff[0] && split);
   cover property (fwd_hit_ff[0]);
   cover property (mem_event_a_ff[0]);
endmodule // issue_timing_chk

bind inorder_mem_issue_timing issue_timing_chk u_chk (
   .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
   .pend_store(pend_store), .in_ready_ff(in_ready_ff), .issue_ff(issue_ff),
   .fwd_hit_ff(fwd_hit_ff), .mem_event_a_ff(mem_event_a_ff),
   .mem_event_a_cnt_ff(mem_event_a_cnt_ff), .div_op_cnt_ff(div_op_cnt_ff),
   .div_busy_cnt_ff(div_busy_cnt_ff)
);

/* testbench/issue_feeder.sv */
// issue stage and store buffer model in front of the timing block
// assumes push is driven after the rising edge; one request held per thread
`timescale 1ns/1ps
module issue_feeder (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] push,
   input wire issue_timing_pkg::issue_req_t [1:0] desc,
   input wire issue_timing_pkg::store_ent_t [1:0] st,
   input wire logic [1:0] in_ready_ff,
   output logic [1:0] req_valid,
   output issue_timing_pkg::issue_req_t [1:0] req,
   output issue_timing_pkg::store_ent_t [1:0] pend_store
);
   logic [1:0] nxt_valid;
   issue_timing_pkg::issue_req_t [1:0] nxt_req;
   // request held until taken; idle descriptor toggles every cycle
   always_comb
   begin
      for (int t = 0; t < 2; t++)
      begin
         nxt_valid[t] = req_valid[t] && !in_ready_ff[t];
         nxt_req[t] = nxt_valid[t] ? req[t] : ~req[t];
         if (push[t] && !nxt_valid[t])
         begin
            nxt_valid[t] = 1'b1;
            nxt_req[t] = desc[t];
         end
      end
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         req_valid <= 2'h0;
      else
         req_valid <= nxt_valid;
      req <= nxt_req;
   end
   assign pend_store = st;
endmodule // issue_feeder

/* testbench/test_inorder_mem_issue_timing.sv */
// self-checking bench for the issue timing block
// assumes the feeder model presents requests; thread 0 carries most traffic
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin fails++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module test_inorder_mem_issue_timing;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] push = 2'h0;
   issue_timing_pkg::issue_req_t [1:0] desc = '0;
   issue_timing_pkg::store_ent_t [1:0] st = '0;
   issue_timing_pkg::issue_req_t [1:0] req;
   issue_timing_pkg::store_ent_t [1:0] pend_store;
   logic [1:0] req_valid, in_ready_ff, issue_ff, fwd_hit_ff, mem_event_a_ff;
   logic [31:0] mem_event_a_cnt_ff, div_op_cnt_ff, div_busy_cnt_ff;
   int fails = 0;
   int compares = 0;
   int th = 0;
   always #2.5 clk = ~clk;
   issue_feeder feeder (.clk(clk), .rst_n(rst_n), .push(push), .desc(desc),
      .st(st), .in_ready_ff(in_ready_ff), .req_valid(req_valid), .req(req),
      .pend_store(pend_store));
   inorder_mem_issue_timing DUT (.clk(clk), .rst_n(rst_n),
      .req_valid(req_valid), .req(req), .pend_store(pend_store),
      .in_ready_ff(in_ready_ff), .issue_ff(issue_ff), .fwd_hit_ff(fwd_hit_ff),
      .mem_event_a_ff(mem_event_a_ff), .mem_event_a_cnt_ff(mem_event_a_cnt_ff),
      .div_op_cnt_ff(div_op_cnt_ff), .div_busy_cnt_ff(div_busy_cnt_ff));
   task automatic complete_run;
      if (fails == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic hang;
      fails++;
      complete_run();
   endtask
   function automatic issue_timing_pkg::issue_req_t ld(input logic [2:0] s,
      input logic [11:0] a);
      ld = '0;
      ld.is_mem = 1'b1;
      ld.is_load = 1'b1;
      ld.is_int = 1'b1;
      ld.size_log2 = s;
      ld.addr = a;
   endfunction
   task automatic drain;
      int k;
      @(posedge clk);
      push <= 2'h0;
      for (k = 0; k < 100; k++)
      begin
         @(posedge clk);
         // both slots empty; the 20 cycles below let the shared units settle
         if (req_valid == 2'h0 && in_ready_ff == 2'h3)
            break;
      end
      if (k == 100)
         hang();
      repeat (20) @(posedge clk);
   endtask
   // one instruction on thread th: cycles from take cycle to issue pulse
   task automatic lat_chk(input issue_timing_pkg::issue_req_t d, input int el,
      input logic ef);
      int k;
      int n;
      logic e;
      e = 1'b0;
      @(posedge clk);
      desc[th] <= d;
      push[th] <= 1'b1;
      @(posedge clk);
      push[th] <= 1'b0;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (req_valid[th] && in_ready_ff[th])
            break;
      end
      // take cycle is 0; the first sample below falls in cycle 2
      for (n = 2; n < 50; n++)
      begin
         @(posedge clk);
         #1;
         e |= mem_event_a_ff[th];
         if (issue_ff[th])
            break;
      end
      if (k == 50 || n == 50)
         hang();
      `CHK(n, el, "issue latency")
      `CHK(fwd_hit_ff[th], ef, "forward flag")
      `CHK(e, el == 8, "mem_event_a event")
      drain();
   endtask
   // streams da then db; cycles between the first two issue pulses
   task automatic gap_chk(input logic [1:0] m,
      input issue_timing_pkg::issue_req_t da, db, input int eg);
      int k;
      int n;
      @(posedge clk);
      desc <= {db, da};
      push <= m;
      @(posedge clk);
      desc[0] <= db;
      for (k = 0; k < 60; k++)
      begin
         @(posedge clk);
         #1;
         if ((issue_ff & m) != 2'h0)
            break;
      end
      for (n = 1; n < 60; n++)
      begin
         @(posedge clk);
         #1;
         if ((issue_ff & m) != 2'h0)
            break;
      end
      if (k == 60 || n == 60)
         hang();
      `CHK(n, eg, "issue spacing")
      drain();
   endtask
   task automatic set_st(input logic [2:0] s, input logic [11:0] a);
      @(posedge clk);
      st[th] <= {2'h3, s, a};
   endtask
   task automatic sc_forward;
      logic [31:0] c;
      issue_timing_pkg::issue_req_t d;
      c = mem_event_a_cnt_ff;
      set_st(3'h2, 12'h104);
      lat_chk(ld(3'h2, 12'h104), 2, 1'b1);
      lat_chk(ld(3'h2, 12'h106), 8, 1'b0);
      d = ld(3'h2, 12'h104);
      d.is_int = 1'b0;
      lat_chk(d, 8, 1'b0);
      set_st(3'h3, 12'h108);
      lat_chk(ld(3'h3, 12'h108), 2, 1'b1);
      set_st(3'h4, 12'h110);
      lat_chk(ld(3'h4, 12'h110), 8, 1'b0);
      lat_chk(ld(3'h2, 12'h200), 2, 1'b0);
      // same forwarding pair on the second thread
      th = 1;
      set_st(3'h2, 12'h104);
      lat_chk(ld(3'h2, 12'h104), 2, 1'b1);
      lat_chk(ld(3'h1, 12'h104), 8, 1'b0);
      th = 0;
      `CHK(mem_event_a_cnt_ff, c + 32'h4, "mem_event_a count")
   endtask
   task automatic sc_split;
      @(posedge clk);
      st[0] <= '0;
      lat_chk(ld(3'h4, 12'h03C), 16, 1'b0);
      lat_chk(ld(3'h4, 12'h030), 2, 1'b0);
      lat_chk(ld(3'h0, 12'h300), 2, 1'b0);
      lat_chk(ld(3'h0, 12'h301), 3, 1'b0);
      lat_chk(ld(3'h1, 12'h302), 3, 1'b0);
      lat_chk(ld(3'h0, 12'h304), 2, 1'b0);
   endtask
   task automatic sc_segments;
      issue_timing_pkg::issue_req_t d;
      logic [5:0] cf [10] = '{6'h00, 6'h04, 6'h06, 6'h10, 6'h1E, 6'h0F,
         6'h0E, 6'h26, 6'h2E, 6'h0D};
      int gp [10] = '{2, 9, 2, 2, 2, 2, 9, 9, 9, 9};
      for (int i = 0; i < 10; i++)
      begin
         d = ld(3'h2, 12'h400);
         d.seg = issue_timing_pkg::seg_sel_t'(cf[i][5:3]);
         d.base_nonzero = cf[i][2];
         d.base_line_aligned = cf[i][1];
         d.string_dst = cf[i][0];
         gap_chk(2'h1, d, d, gp[i]);
      end
   endtask
   task automatic sc_fp_div;
      logic [31:0] c;
      logic [31:0] b;
      issue_timing_pkg::issue_req_t d;
      issue_timing_pkg::issue_req_t e;
      d = '0;
      e = '0;
      d.is_fp = 1'b1;
      e.dep_fp = 1'b1;
      gap_chk(2'h1, d, e, 3);
      d = '0;
      d.is_pd = 1'b1;
      gap_chk(2'h3, d, d, 9);
      d = '0;
      d.is_div = 1'b1;
      d.div_bits = 7'h0A;
      d.div_lz = 7'h02;
      gap_chk(2'h1, d, d, 10);
      gap_chk(2'h3, d, d, 10);
      c = div_op_cnt_ff;
      b = div_busy_cnt_ff;
      lat_chk(d, 2, 1'b0);
      `CHK(div_op_cnt_ff, c + 32'h1, "divide count")
      `CHK(div_busy_cnt_ff, b + 32'hA, "busy count")
      d.div_bits = 7'h03;
      d.div_lz = 7'h05;
      gap_chk(2'h1, d, d, 3);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      sc_forward();
      sc_split();
      sc_segments();
      sc_fp_div();
      complete_run();
   end
endmodule // test_inorder_mem_issue_timing
